/* File: logic/tfr_temp_fault.sv */
// Behaviour
// RL1 - Response code 10 disables output on over-temperature fault; other codes unused.
// RL2 - Fault pulls alert low and sets a fault bit held until clear-faults.
// RL3 - Retry field 000 keeps output off with no restart until faults cleared.
// RL4 - Retry 001-111 restarts until enable off, bias lost or other fault.
// RL5 - No restart attempt until temperature is below the over-temperature warning.
// RL6 - Restart interval is (delay field + 1) times 35 ms.
// RL7 - Above over-temperature warning sets summary and warning bits and alerts host.
// RL8 - Below under-temperature warning sets summary and warning bits and alerts host.
// RL9 - With under-temperature retry, restart waits for temperature above its warning.
// RL10 - Over-temperature warning writes outside 0 to 175 C are rejected.
// RL11 - Under-temperature warning writes outside -55 to 25 C are rejected.
// RL12 - Thresholds are Linear-11: 5-bit signed exponent, 11-bit signed mantissa.
// RL13 - Host keeps warnings on the safe side of fault limits for retry.
// RL14 - Retry delay counts from fault detection to the restart attempt.
// RL15 - Over-temperature fault also recorded in bit 1 of manufacturer status.
// RL16 - Each measurement is compared with both thresholds in measurement scale.
`timescale 1ns/1ps
module tfr_temp_fault #(
    parameter int RETRY_UNIT_CYCLES = tfr_pkg::RETRY_UNIT_CYCLES
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_wdata,
    input wire logic temp_valid,
    input wire logic signed [15:0] temp_value,
    input wire logic ot_fault,
    input wire logic ut_retry,
    input wire logic enable_on,
    input wire logic bias_ok,
    input wire logic other_shutdown,
    output logic [15:0] rd_data,
    output logic rd_valid,
    output logic write_rejected,
    output logic alert_line_n,
    output logic output_en,
    output logic restart_pulse,
    output logic [7:0] status_temp
);

    // ****************************************
    // Configuration registers
    // ****************************************
    logic [7:0] resp_reg, resp_next;
    logic [15:0] ot_warn_lim_reg, ot_warn_lim_next;
    logic [15:0] ut_warn_lim_reg, ut_warn_lim_next;
    logic [15:0] rd_data_reg, rd_data_next;
    logic rd_valid_reg, rd_valid_next;
    logic reject_reg, reject_next;
    logic [7:0] stat_reg, stat_next;
    logic mfr_ot_reg, mfr_ot_next;
    logic alert_n_reg, alert_n_next;
    logic below_ot_reg, below_ot_next;
    logic above_ut_reg, above_ut_next;
    logic is_wr, is_rd, clr;
    logic signed [31:0] wr_fix, temp_fix;

    always_comb begin
        is_wr = cmd_valid && cmd_write;
        is_rd = cmd_valid && !cmd_write;
        clr = is_wr && (cmd_code == tfr_pkg::CMD_CLEAR_FAULTS);
        wr_fix = tfr_pkg::lin11_to_fix(cmd_wdata); // RL12
        temp_fix = 32'(temp_value);
        resp_next = resp_reg;
        ot_warn_lim_next = ot_warn_lim_reg;
        ut_warn_lim_next = ut_warn_lim_reg;
        reject_next = 1'b0;
        rd_valid_next = is_rd;
        rd_data_next = rd_data_reg;
        if (is_wr) begin
            unique case (cmd_code)
                tfr_pkg::CMD_OT_RESPONSE: begin
                    resp_next = cmd_wdata[7:0];
                end
                tfr_pkg::CMD_OT_WARN: begin
                    if (tfr_pkg::in_span(wr_fix, tfr_pkg::OT_WARN_MIN_C,
                                         tfr_pkg::OT_WARN_MAX_C)) begin
                        ot_warn_lim_next = cmd_wdata;
                    end else begin
                        reject_next = 1'b1; // RL10
                    end
                end
                tfr_pkg::CMD_UT_WARN: begin
                    if (tfr_pkg::in_span(wr_fix, tfr_pkg::UT_WARN_MIN_C,
                                         tfr_pkg::UT_WARN_MAX_C)) begin
                        ut_warn_lim_next = cmd_wdata;
                    end else begin
                        reject_next = 1'b1; // RL11
                    end
                end
                default: begin
                end
            endcase
        end
        if (is_rd) begin
            unique case (cmd_code)
                tfr_pkg::CMD_OT_RESPONSE: rd_data_next = {8'h00, resp_reg};
                tfr_pkg::CMD_OT_WARN: rd_data_next = ot_warn_lim_reg;
                tfr_pkg::CMD_UT_WARN: rd_data_next = ut_warn_lim_reg;
                tfr_pkg::CMD_STATUS_WORD: begin
                    rd_data_next = '0;
                    rd_data_next[tfr_pkg::SW_TEMP_BIT] = |stat_reg; // RL7 RL8
                end
                tfr_pkg::CMD_STATUS_TEMP: rd_data_next = {8'h00, stat_reg};
                tfr_pkg::CMD_STATUS_MFR: begin
                    rd_data_next = '0;
                    rd_data_next[tfr_pkg::MFR_OT_BIT] = mfr_ot_reg; // RL15
                end
                default: rd_data_next = 16'h0000;
            endcase
        end

        // ****************************************
        // Measurement compare and sticky flags
        // ****************************************
        below_ot_next = below_ot_reg;
        above_ut_next = above_ut_reg;
        stat_next = clr ? 8'h00 : stat_reg; // RL2
        mfr_ot_next = clr ? 1'b0 : mfr_ot_reg;
        if (temp_valid) begin
            below_ot_next = temp_fix < tfr_pkg::lin11_to_fix(ot_warn_lim_reg); // RL16 RL5
            above_ut_next = temp_fix > tfr_pkg::lin11_to_fix(ut_warn_lim_reg); // RL16 RL9
            if (temp_fix > tfr_pkg::lin11_to_fix(ot_warn_lim_reg)) begin
                stat_next[tfr_pkg::ST_OT_WARN_BIT] = 1'b1; // RL7
            end
            if (temp_fix < tfr_pkg::lin11_to_fix(ut_warn_lim_reg)) begin
                stat_next[tfr_pkg::ST_UT_WARN_BIT] = 1'b1; // RL8
            end
        end
        if (ot_fault) begin
            stat_next[tfr_pkg::ST_OT_FAULT_BIT] = 1'b1; // RL2
            mfr_ot_next = 1'b1; // RL15
        end
        alert_n_next = !((|stat_next) || mfr_ot_next); // RL2 RL7 RL8
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            resp_reg <= tfr_pkg::OT_RESPONSE_RST;
            ot_warn_lim_reg <= tfr_pkg::OT_WARN_RST;
            ut_warn_lim_reg <= tfr_pkg::UT_WARN_RST;
            rd_data_reg <= '0;
            rd_valid_reg <= 1'b0;
            reject_reg <= 1'b0;
            stat_reg <= '0;
            mfr_ot_reg <= 1'b0;
            alert_n_reg <= 1'b1;
            below_ot_reg <= 1'b1;
            above_ut_reg <= 1'b1;
        end else begin
            resp_reg <= resp_next;
            ot_warn_lim_reg <= ot_warn_lim_next;
            ut_warn_lim_reg <= ut_warn_lim_next;
            rd_data_reg <= rd_data_next;
            rd_valid_reg <= rd_valid_next;
            reject_reg <= reject_next;
            stat_reg <= stat_next;
            mfr_ot_reg <= mfr_ot_next;
            alert_n_reg <= alert_n_next;
            below_ot_reg <= below_ot_next;
            above_ut_reg <= above_ut_next;
        end
    end

    // ****************************************
    // Fault response sequencer
    // ****************************************
    tfr_pkg::tfr_state_t state_reg, state_next;
    logic out_en_reg, out_en_next;
    logic restart_reg, restart_next;
    logic tmr_start_reg, tmr_start_next;
    logic tmr_done;
    logic stop_req, cool, disable_mode;

    always_comb begin
        stop_req = !enable_on || !bias_ok || other_shutdown; // RL4
        cool = below_ot_reg && (!ut_retry || above_ut_reg); // RL5 RL9
        disable_mode = resp_reg[tfr_pkg::RESP_MODE_HI:tfr_pkg::RESP_MODE_LO] ==
                       tfr_pkg::RESP_MODE_DISABLE;
        state_next = state_reg;
        restart_next = 1'b0;
        tmr_start_next = 1'b0;
        unique case (state_reg)
            tfr_pkg::ST_OFF: begin
                if (!stop_req) begin
                    state_next = tfr_pkg::ST_RUN;
                end
            end
            tfr_pkg::ST_RUN: begin
                if (ot_fault && disable_mode) begin // RL1
                    if (resp_reg[tfr_pkg::RESP_RETRY_HI:tfr_pkg::RESP_RETRY_LO] ==
                        tfr_pkg::RETRY_NONE) begin
                        state_next = tfr_pkg::ST_LATCHED; // RL3
                    end else begin
                        state_next = tfr_pkg::ST_DELAY;
                        tmr_start_next = 1'b1; // RL14
                    end
                end else if (stop_req) begin
                    state_next = tfr_pkg::ST_OFF;
                end
            end
            tfr_pkg::ST_LATCHED: begin
                if (clr) begin
                    state_next = tfr_pkg::ST_OFF; // RL3
                end
            end
            tfr_pkg::ST_DELAY: begin
                if (stop_req) begin
                    state_next = tfr_pkg::ST_OFF; // RL4
                end else if (tmr_done) begin
                    state_next = tfr_pkg::ST_COOL; // RL6
                end
            end
            tfr_pkg::ST_COOL: begin
                if (stop_req) begin
                    state_next = tfr_pkg::ST_OFF; // RL4
                end else if (cool) begin
                    state_next = tfr_pkg::ST_RUN; // RL5
                    restart_next = 1'b1;
                end
            end
            default: state_next = tfr_pkg::ST_OFF;
        endcase
        out_en_next = state_next == tfr_pkg::ST_RUN;
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            state_reg <= tfr_pkg::ST_OFF;
            out_en_reg <= 1'b0;
            restart_reg <= 1'b0;
            tmr_start_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            out_en_reg <= out_en_next;
            restart_reg <= restart_next;
            tmr_start_reg <= tmr_start_next;
        end
    end

    tfr_retry_timer #(
        .UNIT_CYCLES(RETRY_UNIT_CYCLES)
    ) u_timer (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .start(tmr_start_reg),
        .delay_code(resp_reg[tfr_pkg::RESP_DELAY_HI:tfr_pkg::RESP_DELAY_LO]), // RL6
        .done(tmr_done)
    );

    // ****************************************
    // Outputs
    // ****************************************
    assign rd_data = rd_data_reg;
    assign rd_valid = rd_valid_reg;
    assign write_rejected = reject_reg;
    assign alert_line_n = alert_n_reg;
    assign output_en = out_en_reg;
    assign restart_pulse = restart_reg;
    assign status_temp = stat_reg;

endmodule

/* File: shared/tfr_pkg.sv */
package tfr_pkg;

    // ****************************************
    // Command codes
    // ****************************************
    localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0] CMD_OT_RESPONSE = 8'h50;
    localparam logic [7:0] CMD_OT_WARN = 8'h51;
    localparam logic [7:0] CMD_UT_WARN = 8'h52;
    localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
    localparam logic [7:0] CMD_STATUS_TEMP = 8'h7d;
    localparam logic [7:0] CMD_STATUS_MFR = 8'h80;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] OT_RESPONSE_RST = 8'h80;
    localparam logic [15:0] OT_WARN_RST = 16'heb70;
    localparam logic [15:0] UT_WARN_RST = 16'hdc40;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int RESP_MODE_HI = 7;
    localparam int RESP_MODE_LO = 6;
    localparam int RESP_RETRY_HI = 5;
    localparam int RESP_RETRY_LO = 3;
    localparam int RESP_DELAY_HI = 2;
    localparam int RESP_DELAY_LO = 0;
    localparam logic [1:0] RESP_MODE_DISABLE = 2'h2;
    localparam logic [2:0] RETRY_NONE = 3'h0;
    localparam int LIN_EXP_HI = 15;
    localparam int LIN_EXP_LO = 11;
    localparam int LIN_MANT_HI = 10;
    localparam int SW_TEMP_BIT = 2;
    localparam int ST_OT_FAULT_BIT = 7;
    localparam int ST_OT_WARN_BIT = 6;
    localparam int ST_UT_WARN_BIT = 5;
    localparam int MFR_OT_BIT = 1;

    // ****************************************
    // Measurement scale and limits
    // ****************************************
    localparam int TEMP_FRAC = 4;
    localparam int OT_WARN_MIN_C = 0;
    localparam int OT_WARN_MAX_C = 175;
    localparam int UT_WARN_MIN_C = -55;
    localparam int UT_WARN_MAX_C = 25;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_HZ = 10000000;
    localparam int RETRY_UNIT_MS = 35;
    localparam int RETRY_UNIT_CYCLES = CLK_HZ / 1000 * RETRY_UNIT_MS;
    localparam int UNIT_CNT_W = 20;

    typedef enum logic [2:0] {
        ST_OFF,
        ST_RUN,
        ST_LATCHED,
        ST_DELAY,
        ST_COOL
    } tfr_state_t;

    // Linear-11 word to signed fixed point with TEMP_FRAC fraction bits
    function automatic logic signed [31:0] lin11_to_fix(input logic [15:0] w);
        logic signed [4:0] n;
        logic signed [31:0] y;
        int sh;
        n = signed'(w[LIN_EXP_HI:LIN_EXP_LO]);
        y = 32'(signed'(w[LIN_MANT_HI:0]));
        sh = int'(n) + TEMP_FRAC;
        if (sh >= 0) begin
            lin11_to_fix = y <<< sh;
        end else begin
            lin11_to_fix = y >>> (-sh);
        end
    endfunction

    function automatic logic in_span(input logic signed [31:0] v, input int lo_c,
                                     input int hi_c);
        in_span = (v >= (lo_c <<< TEMP_FRAC)) && (v <= (hi_c <<< TEMP_FRAC));
    endfunction

endpackage

/* File: logic/tfr_retry_timer.sv */
`timescale 1ns/1ps
module tfr_retry_timer #(
    parameter int UNIT_CYCLES = tfr_pkg::RETRY_UNIT_CYCLES
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic start,
    input wire logic [2:0] delay_code,
    output logic done
);

    // ****************************************
    // Delay of (code + 1) units from start
    // ****************************************
    logic [tfr_pkg::UNIT_CNT_W-1:0] cyc_reg, cyc_next;
    logic [2:0] units_reg, units_next;
    logic [2:0] target_reg, target_next;
    logic busy_reg, busy_next;
    logic done_reg, done_next;

    localparam logic [tfr_pkg::UNIT_CNT_W-1:0] LAST_CYC =
        tfr_pkg::UNIT_CNT_W'(UNIT_CYCLES - 1);

    always_comb begin
        cyc_next = cyc_reg;
        units_next = units_reg;
        target_next = target_reg;
        busy_next = busy_reg;
        done_next = 1'b0;
        if (start) begin
            cyc_next = '0;
            units_next = '0;
            target_next = delay_code;
            busy_next = 1'b1;
        end else if (busy_reg) begin
            if (cyc_reg == LAST_CYC) begin
                cyc_next = '0;
                if (units_reg == target_reg) begin
                    busy_next = 1'b0;
                    done_next = 1'b1;
                end else begin
                    units_next = units_reg + 3'h1;
                end
            end else begin
                cyc_next = cyc_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            cyc_reg <= '0;
            units_reg <= '0;
            target_reg <= '0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            cyc_reg <= cyc_next;
            units_reg <= units_next;
            target_reg <= target_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
        end
    end

    assign done = done_reg;

endmodule

/* File: testbench/tfr_temp_fault_sva.sv */
`timescale 1ns/1ps
// ************
// Fault checker
// ************
module tfr_chk #(
    parameter int RETRY_UNIT_CYCLES = 10
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_wdata,
    input wire logic ot_fault,
    input wire logic enable_on,
    input wire logic bias_ok,
    input wire logic other_shutdown,
    input wire logic alert_line_n,
    input wire logic output_en,
    input wire logic restart_pulse,
    input wire logic [7:0] status_temp
);
    logic [7:0] resp_reg;
    int gap_reg;
    logic clr;
    assign clr = cmd_valid && cmd_write && cmd_code == tfr_pkg::CMD_CLEAR_FAULTS;
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            resp_reg <= tfr_pkg::OT_RESPONSE_RST;
            gap_reg <= 0;
        end else begin
            if (cmd_valid && cmd_write && cmd_code == tfr_pkg::CMD_OT_RESPONSE) begin
                resp_reg <= cmd_wdata[7:0];
            end
            if (ot_fault && output_en) begin
                gap_reg <= 0;
            end else if (gap_reg < 1000000) begin
                gap_reg <= gap_reg + 1;
            end
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    a_fault_off: assert property (ot_fault && output_en && resp_reg[7:6] == 2'h2
        |=> !output_en && status_temp[7]) else $error("output kept on after fault");
    a_fault_alert: assert property ($rose(status_temp[7]) |=> !alert_line_n)
        else $error("no alert on fault");
    a_fault_held: assert property ($fell(status_temp[7])
        |-> $past(clr) || $past(clr, 2) || !$past(nrst)) else $error("fault flag lost");
    a_latch_off: assert property (!output_en && status_temp[7] && resp_reg[5:3] == 3'h0
        |=> !output_en) else $error("restart without retry");
    a_retry_gap: assert property (restart_pulse
        |-> gap_reg >= (int'(resp_reg[2:0]) + 1) * RETRY_UNIT_CYCLES) else $error("retry early");
    a_stop_off: assert property (!enable_on || !bias_ok || other_shutdown
        |=> !output_en) else $error("output on while stopped");
    a_warn_alert: assert property ($rose(status_temp[6]) || $rose(status_temp[5])
        |=> !alert_line_n) else $error("no alert on warning");
    a_alert_idle: assert property (status_temp == 8'h00 |-> alert_line_n)
        else $error("alert without flag");
    a_restart_edge: assert property (restart_pulse
        |-> output_en && !$past(output_en) && $past(enable_on && bias_ok && !other_shutdown))
        else $error("bad restart");
endmodule

bind tfr_temp_fault tfr_chk #(.RETRY_UNIT_CYCLES(RETRY_UNIT_CYCLES)) u_chk (
    .sys_clk(sys_clk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .ot_fault(ot_fault), .enable_on(enable_on),
    .bias_ok(bias_ok), .other_shutdown(other_shutdown), .alert_line_n(alert_line_n),
    .output_en(output_en), .restart_pulse(restart_pulse), .status_temp(status_temp)
);

/* File: testbench/tfr_host.sv */
`timescale 1ns/1ps
// ************
// Host model
// ************
module tfr_host (
    input wire logic sys_clk,
    input wire logic [15:0] rd_data,
    input wire logic rd_valid,
    input wire logic write_rejected,
    output logic cmd_valid,
    output logic cmd_write,
    output logic [7:0] cmd_code,
    output logic [15:0] cmd_wdata
);
    initial begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_code = 8'h00;
        cmd_wdata = 16'h0000;
    end
    // One command, answer one edge later
    task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                        output logic [15:0] q, output logic ans);
        @(posedge sys_clk);
        cmd_valid <= 1'b1;
        cmd_write <= w;
        cmd_code <= c;
        cmd_wdata <= d;
        @(posedge sys_clk);
        cmd_valid <= 1'b0;
        cmd_wdata <= ~d;
        #1;
        q = rd_data;
        ans = w ? write_rejected : rd_valid;
    endtask
endmodule

/* File: testbench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    localparam int U = 10;
    logic sys_clk, nrst, cmd_valid, cmd_write, temp_valid, ot_fault, ut_retry;
    logic enable_on, bias_ok, other_shutdown, rd_valid, write_rejected, alert_line_n;
    logic output_en, restart_pulse;
    logic [7:0] cmd_code, status_temp;
    logic [15:0] cmd_wdata, rd_data;
    logic signed [15:0] temp_value;
    int err_total, checks_done, cyc;
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    tfr_temp_fault #(.RETRY_UNIT_CYCLES(U)) u_dut (
        .sys_clk(sys_clk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .temp_valid(temp_valid),
        .temp_value(temp_value), .ot_fault(ot_fault), .ut_retry(ut_retry),
        .enable_on(enable_on), .bias_ok(bias_ok), .other_shutdown(other_shutdown),
        .rd_data(rd_data), .rd_valid(rd_valid), .write_rejected(write_rejected),
        .alert_line_n(alert_line_n), .output_en(output_en), .restart_pulse(restart_pulse),
        .status_temp(status_temp)
    );
    tfr_host u_host (
        .sys_clk(sys_clk), .rd_data(rd_data), .rd_valid(rd_valid),
        .write_rejected(write_rejected), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata)
    );
    // ************
    // Helpers
    // ************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask
    task automatic rd(input logic [7:0] c, output logic [15:0] q);
        logic a;
        u_host.xfer(1'b0, c, 16'h0000, q, a);
        chk({15'h0, a}, 16'h0001, "read unanswered");
    endtask
    task automatic wr(input logic [7:0] c, input logic [15:0] d, output logic rej);
        logic [15:0] q;
        u_host.xfer(1'b1, c, d, q, rej);
    endtask
    task automatic edges(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic sample(input logic signed [15:0] v);
        @(posedge sys_clk);
        temp_valid <= 1'b1;
        temp_value <= v;
        @(posedge sys_clk);
        temp_valid <= 1'b0;
        #1;
    endtask
    task automatic fault;
        @(posedge sys_clk);
        ot_fault <= 1'b1;
        @(posedge sys_clk);
        ot_fault <= 1'b0;
        #1;
    endtask
    task automatic wait_rs(input int lim, output int n);
        n = 0;
        while (restart_pulse !== 1'b1 && n < lim) begin
            edges(1);
            n++;
        end
    endtask
    // ************
    // Scenarios
    // ************
    task automatic t_reset;
        logic [3:0][7:0] c = {8'h00, 8'h52, 8'h51, 8'h50};
        logic [3:0][15:0] e = {16'h0000, 16'hdc40, 16'heb70, 16'h0080};
        logic [15:0] q;
        chk({14'h0, alert_line_n, output_en}, 16'h0003, "idle state");
        for (int i = 0; i < 4; i++) begin
            rd(c[i], q);
            chk(q, e[i], "reset value");
        end
    endtask
    task automatic t_limits;
        logic [7:0][15:0] d = {16'h001a, 16'h0019, 16'h07c8, 16'h07c9,
                               16'he800, 16'h07ff, 16'hf95f, 16'hf95e};
        logic [7:0] rj = 8'b10100110;
        logic [15:0] keep, q;
        logic [7:0] c;
        logic r;
        for (int i = 0; i < 8; i++) begin
            c = i < 4 ? 8'h51 : 8'h52;
            wr(c, d[i], r);
            chk({15'h0, r}, {15'h0, rj[i]}, "limit verdict");
            if (!rj[i]) keep = d[i];
            rd(c, q);
            chk(q, keep, "limit readback");
        end
    endtask
    task automatic t_warn;
        logic [15:0] q;
        logic r;
        wr(8'h51, 16'h0064, r);
        wr(8'h52, 16'h07ec, r);
        sample(16'sd1600);
        edges(2);
        chk({8'h00, status_temp}, 16'h0000, "flag at limit");
        sample(16'sd1616);
        edges(2);
        chk({7'h0, alert_line_n, status_temp}, 16'h0040, "over warning");
        rd(8'h79, q);
        chk(q & 16'h0004, 16'h0004, "summary bit");
        wr(8'h03, 16'h0000, r);
        sample(-16'sd336);
        edges(2);
        chk({7'h0, alert_line_n, status_temp}, 16'h0020, "under warning");
        rd(8'h79, q);
        chk(q & 16'h0004, 16'h0004, "summary bit");
        wr(8'h03, 16'h0000, r);
        sample(16'sd320);
        edges(2);
        chk({7'h0, alert_line_n, status_temp}, 16'h0100, "flags after clear");
    endtask
    task automatic t_latch;
        logic [15:0] q;
        logic r;
        wr(8'h50, 16'h0040, r);
        fault;
        chk({6'h0, output_en, alert_line_n, status_temp}, 16'h0280, "unused mode");
        wr(8'h03, 16'h0000, r);
        wr(8'h50, 16'h0080, r);
        fault;
        chk({7'h0, output_en, status_temp}, 16'h0080, "fault response");
        edges(5 * U);
        chk({14'h0, output_en, alert_line_n}, 16'h0000, "latched state");
        rd(8'h80, q);
        chk(q & 16'h0002, 16'h0002, "maker fault bit");
        rd(8'h7d, q);
        chk(q & 16'h0080, 16'h0080, "fault flag held");
        wr(8'h03, 16'h0000, r);
        edges(3);
        chk({14'h0, output_en, alert_line_n}, 16'h0003, "after clear");
    endtask
    task automatic t_retry;
        logic [2:0][2:0] dl = {3'h7, 3'h3, 3'h0};
        int n, lo;
        logic r;
        sample(16'sd1616);
        wr(8'h50, 16'h0089, r);
        @(posedge sys_clk);
        ut_retry <= 1'b1;
        fault;
        edges(4 * U);
        chk({15'h0, output_en}, 16'h0000, "restart while hot");
        sample(-16'sd336);
        edges(U);
        chk({15'h0, output_en}, 16'h0000, "restart while cold");
        sample(16'sd320);
        wait_rs(U, n);
        chk({15'h0, restart_pulse}, 16'h0001, "no restart when cool");
        for (int i = 0; i < 3; i++) begin
            wr(8'h50, {8'h00, 5'b10001, dl[i]}, r);
            fault;
            lo = (int'(dl[i]) + 1) * U;
            wait_rs(lo + 6, n);
            chk({14'h0, restart_pulse, n >= lo}, 16'h0003, "retry interval");
        end
        for (int k = 0; k < 3; k++) begin
            @(posedge sys_clk);
            enable_on <= k != 0;
            bias_ok <= k != 1;
            other_shutdown <= k == 2;
            edges(2);
            chk({15'h0, output_en}, 16'h0000, "on while stopped");
            @(posedge sys_clk);
            enable_on <= 1'b1;
            bias_ok <= 1'b1;
            other_shutdown <= 1'b0;
            edges(3);
            chk({15'h0, output_en}, 16'h0001, "no resume");
        end
    endtask
    task automatic wrap_up;
        $display("errors %0d checks %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total++;
            wrap_up;
        end
    end
    initial begin
        nrst = 1'b0;
        temp_valid = 1'b0;
        temp_value = 16'sh0000;
        ot_fault = 1'b0;
        ut_retry = 1'b0;
        enable_on = 1'b1;
        bias_ok = 1'b1;
        other_shutdown = 1'b0;
        err_total = 0;
        checks_done = 0;
        cyc = 0;
        repeat (3) @(posedge sys_clk);
        nrst <= 1'b1;
        edges(2);
        t_reset;
        t_limits;
        t_warn;
        t_latch;
        t_retry;
        @(posedge sys_clk);
        nrst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        nrst <= 1'b1;
        edges(2);
        t_reset;
        wrap_up;
    end
endmodule
